/* cbt_asserts.sv */
/* Port checker for cbt_top, bound into every instance.
   Assumes one clock CLK and the asynchronous reset SYS_RST. */
`timescale 1ns/1ps
`default_nettype none
module cbt_asserts
  import cbt_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  input wire logic CONTROLLER_ENABLE,
  input wire logic RX_FRAME_DONE,
  input wire logic [3:0] RX_OBJECT,
  input wire logic [3:0] RX_LENGTH,
  input wire logic SAMPLE_BIT,
  input wire logic SAMPLE_STROBE,
  input wire logic [14:0] OBJECT_ENABLE,
  input wire logic [14:0] OBJECT_REPLY_VALID,
  input wire logic [14:0] OBJECT_ID_EXTENDED
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  logic [7:0] pg_q;
  // Decodes of paged accesses; a same-cycle frame report wins over a control write
  wire [3:0] obj = pg_q[7:4];
  wire data_acc = (SFR_RD || SFR_WR) && SFR_ADDR == DATA_OFS;
  wire ctl_wr = SFR_WR && SFR_ADDR == CTRL_OFS && obj <= LAST_OBJ
    && !(RX_FRAME_DONE && RX_OBJECT == obj);
  wire rd_void = SFR_RD && obj == 4'hF && (SFR_ADDR == CTRL_OFS || SFR_ADDR == DATA_OFS);
  // Shadow page register, so checks need no view inside the block
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      pg_q <= PAGE_RST;
    else if (SFR_WR && SFR_ADDR == PAGE_OFS)
      pg_q <= SFR_WDATA;
    else if (data_acc && !pg_q[3])
      pg_q[2:0] <= pg_q[2:0] + 3'h1;
  end
  sequence rx_then_read;
    RX_FRAME_DONE && RX_OBJECT == obj && obj <= LAST_OBJ && !SFR_WR
      ##1 SFR_RD && SFR_ADDR == CTRL_OFS && !RX_FRAME_DONE;
  endsequence
  page_readback_a: assert property (SFR_RD && SFR_ADDR == PAGE_OFS |=> SFR_RDATA == pg_q)
    else $error("page read differs from shadow");
  empty_object_a: assert property (rd_void |=> SFR_RDATA == 8'h00)
    else $error("object 15 read not zero");
  cfg_enable_a: assert property (ctl_wr |=> OBJECT_ENABLE[obj] == (|$past(SFR_WDATA[7:6])))
    else $error("object enable wrong after config write");
  reply_flag_a: assert property (ctl_wr |=> OBJECT_REPLY_VALID[obj] == $past(SFR_WDATA[5]))
    else $error("reply valid not written");
  id_ext_a: assert property (ctl_wr |=> OBJECT_ID_EXTENDED[obj] == $past(SFR_WDATA[4]))
    else $error("id extension not written");
  rx_length_a: assert property (rx_then_read |=> SFR_RDATA[3:0] == $past(RX_LENGTH, 2))
    else $error("received length not stored");
  strobe_pulse_a: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE [*2])
    else $error("sample strobes too close");
  bit_moves_a: assert property ($changed(SAMPLE_BIT) |-> SAMPLE_STROBE)
    else $error("sampled bit changed off the sample point");
  idle_quiet_a: assert property (!CONTROLLER_ENABLE [*3] |-> !SAMPLE_STROBE)
    else $error("strobe while disabled");
  rdata_hold_a: assert property (!SFR_RD |=> $stable(SFR_RDATA))
    else $error("read data moved without a read");
  c_dominant: cover property (SAMPLE_STROBE && !SAMPLE_BIT);
  c_ctl: cover property (ctl_wr);
  c_rx: cover property (rx_then_read);
endmodule // cbt_asserts
bind cbt_top cbt_asserts u_asserts (.CLK, .SYS_RST, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA,
  .SFR_RDATA, .CONTROLLER_ENABLE, .RX_FRAME_DONE, .RX_OBJECT, .RX_LENGTH, .SAMPLE_BIT,
  .SAMPLE_STROBE, .OBJECT_ENABLE, .OBJECT_REPLY_VALID, .OBJECT_ID_EXTENDED);
`default_nettype wire

/* cbt_bittime.sv */
/*
  Bit timing: prescaler, segment sequencing and resynchronisation.
  Assumes the configuration is stable while enable is high, and rx is
  synchronised to CLK. Recessive is 1.
*/
`timescale 1ns/1ps
`default_nettype none
module cbt_bittime
  import cbt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [5:0] baud_prescaler,
  input wire logic [2:0] prs,
  input wire logic [1:0] resync_jump_width,
  input wire cbt_pkg::cbt_timing_t cfg,
  input wire logic rx,
  input wire logic sampled,
  output logic half_tick,
  output logic sample_bit_q,
  output logic sample_strobe_q
);
  typedef enum logic [3:0] {
    SEG_SYNC = 4'h1,
    SEG_PROP = 4'h2,
    SEG_PH1 = 4'h4,
    SEG_PH2 = 4'h8
  } cbt_seg_t;

  cbt_seg_t seg_q;
  logic [5:0] div_q;
  logic [4:0] cnt_q;
  logic [4:0] lim_q;
  logic rx_prev_q;

  wire tq_tick = enable && (div_q == baud_prescaler);
  // Half-quantum tick drives the sampler in the top
  assign half_tick = enable && ((div_q == baud_prescaler) || (div_q == {1'b0, baud_prescaler[5:1]}));
  wire fall = rx_prev_q && !rx;
  wire [4:0] jump = {3'h0, resync_jump_width} + 5'h1;
  wire [4:0] ph1_len = {2'h0, cfg.phase_seg_one} + 5'h1;
  wire [4:0] ph2_len = {2'h0, cfg.phase_seg_two} + 5'h1;
  wire [4:0] prs_len = {2'h0, prs} + 5'h1;
  wire seg_end = tq_tick && (cnt_q + 5'h1 >= lim_q);
  // Early edge in phase two: cut it short by at most the jump width
  wire [4:0] cut_lim = (ph2_len > jump + cnt_q + 5'h1) ? ph2_len - jump : cnt_q + 5'h1;

  // Prescaler: one time quantum every brp+1 cycles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_q <= 6'h00;
    else if (!enable || div_q == baud_prescaler)
      div_q <= 6'h00;
    else
      div_q <= div_q + 6'h01;
  end

  // Segment sequencer with resynchronisation on falling edges
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seg_q <= SEG_SYNC;
      cnt_q <= 5'h00;
      lim_q <= 5'h01;
      rx_prev_q <= 1'b1;
      sample_bit_q <= 1'b1;
      sample_strobe_q <= 1'b0;
    end
    else
    begin
      rx_prev_q <= rx;
      sample_strobe_q <= 1'b0;
      if (!enable)
      begin
        seg_q <= SEG_SYNC;
        cnt_q <= 5'h00;
        lim_q <= 5'h01;
      end
      else if (seg_end)
      begin
        cnt_q <= 5'h00;
        case (seg_q)
          SEG_SYNC:
          begin
            seg_q <= SEG_PROP;
            lim_q <= prs_len;
          end
          SEG_PROP:
          begin
            seg_q <= SEG_PH1;
            lim_q <= ph1_len;
          end
          SEG_PH1:
          begin
            seg_q <= SEG_PH2;
            lim_q <= ph2_len;
            sample_bit_q <= sampled;
            sample_strobe_q <= 1'b1;
          end
          default:
          begin
            seg_q <= SEG_SYNC;
            lim_q <= 5'h01;
          end
        endcase
      end
      else
      begin
        // Edges only move the limit, so a quantum that coincides still counts
        if (tq_tick)
          cnt_q <= cnt_q + 5'h01;
        if (fall && seg_q == SEG_PH1)
          lim_q <= ph1_len + jump; // Late edge lengthens phase one
        else if (fall && seg_q == SEG_PH2)
          lim_q <= cut_lim;
      end
    end
  end
endmodule // cbt_bittime
`default_nettype wire

/* cbt_can_node.sv */
/* Far CAN node: sends a 16-bit pattern, first bit on the left.
   Assumes the bus idles recessive (1) through its pull-up. */
`timescale 1ns/1ps
`default_nettype none
module cbt_can_node
(
  input wire logic clk,
  input wire logic send,
  input wire logic [7:0] bit_cycles,
  input wire logic [15:0] pattern,
  output logic can_rx
);
  logic [15:0] sh_q = 16'h0000;
  logic [4:0] left_q = 5'h00;
  logic [7:0] cnt_q = 8'h00;
  // Released bus goes recessive, never holds the last bit
  assign can_rx = (left_q != 5'h00) ? sh_q[15] : 1'b1;
  // One bit each bit_cycles clocks
  always_ff @(posedge clk)
  begin
    if (send)
    begin
      sh_q <= pattern;
      left_q <= 5'h10;
      cnt_q <= 8'h00;
    end
    else if (left_q != 5'h00)
    begin
      cnt_q <= (cnt_q == bit_cycles - 8'h01) ? 8'h00 : cnt_q + 8'h01;
      if (cnt_q == bit_cycles - 8'h01)
      begin
        sh_q <= {sh_q[14:0], 1'b0};
        left_q <= left_q - 5'h01;
      end
    end
  end
endmodule // cbt_can_node
`default_nettype wire

/* cbt_pkg.sv */
/*
  Constants, register map and carrier types for the bit timing and
  message object access block of the CAN controller.
  Assumes the special function register port of the host core and a
  protocol engine that reports received frames.
*/
`default_nettype none
package cbt_pkg;
  // Register offsets on the special function register port
  localparam logic [7:0] PAGE_OFS = 8'hB1;
  localparam logic [7:0] STATUS_OFS = 8'hB2;
  localparam logic [7:0] CTRL_OFS = 8'hB3;
  localparam logic [7:0] TIMING_OFS = 8'hB6;
  localparam logic [7:0] DATA_OFS = 8'hFA;
  // Reset values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h00;
  // Object geometry
  localparam int NUM_OBJ = 15;
  localparam int DATA_BYTES = 8;
  localparam logic [3:0] LAST_OBJ = 4'hE;
  localparam logic [3:0] MAX_DLC = 4'h8;
  // Field positions
  localparam int STATUS_DLCW_BIT = 7;
  localparam int TIMING_RSVD_BIT = 7;
  localparam logic [1:0] CFG_DISABLED = 2'h0;

  // Page register layout
  typedef struct packed {
    logic [3:0] object_number;
    logic index_autoinc_n;
    logic [2:0] data_byte_index;
  } cbt_page_t;

  // Object control and length layout
  typedef struct packed {
    logic [1:0] object_config;
    logic reply_valid;
    logic id_extended;
    logic [3:0] data_length;
  } cbt_ctrl_t;

  // Third timing register layout
  typedef struct packed {
    logic reserved;
    logic [2:0] phase_seg_two;
    logic [2:0] phase_seg_one;
    logic sample_type;
  } cbt_timing_t;
endpackage
`default_nettype wire

/* cbt_sample3.sv */
/*
  Bus sampler: single sample or majority of three samples spaced half
  a time quantum apart, ending at the sample point.
  Assumes rx is already synchronised to CLK and the tick enables come
  from the prescaler in the bit timing module.
*/
`timescale 1ns/1ps
`default_nettype none
module cbt_sample3
  import cbt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rx,
  input wire logic half_tick,
  input wire logic sample_type,
  output logic sampled
);
  logic [1:0] hist_q;
  wire maj3 = (hist_q[1] & hist_q[0]) | (hist_q[1] & rx) | (hist_q[0] & rx);
  wire pick = sample_type ? maj3 : rx;

  // Keep the two samples taken half and one quantum before now
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hist_q <= 2'h3;
    else if (half_tick)
      hist_q <= {hist_q[0], rx};
  end

  assign sampled = pick;
endmodule // cbt_sample3
`default_nettype wire

/* cbt_top.sv */
/*
  Top of the bit timing and message object access block: page, object
  control, object status, data and third timing registers on the
  special function register port, plus the bit sampler.
  Assumes single-cycle read and write strobes from the host core on CLK,
  and a protocol engine on CLK reporting received frames.
*/
`timescale 1ns/1ps
`default_nettype none
module cbt_top
  import cbt_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic CONTROLLER_ENABLE,
  input wire logic [5:0] BAUD_PRESCALER,
  input wire logic [2:0] PROP_SEG,
  input wire logic [1:0] RESYNC_JUMP_WIDTH,
  input wire logic CAN_RX,
  input wire logic RX_FRAME_DONE,
  input wire logic [3:0] RX_OBJECT,
  input wire logic [3:0] RX_LENGTH,
  output logic SAMPLE_BIT,
  output logic SAMPLE_STROBE,
  output logic [14:0] OBJECT_ENABLE,
  output logic [14:0] OBJECT_REPLY_VALID,
  output logic [14:0] OBJECT_ID_EXTENDED
);
  import cbt_pkg::*;

  cbt_page_t page_q;
  cbt_timing_t timing_q;
  cbt_ctrl_t ctrl_q [NUM_OBJ];
  logic [NUM_OBJ-1:0] dlcw_q;
  logic [7:0] data_q [NUM_OBJ][DATA_BYTES];
  logic [7:0] rdata_q;
  logic [NUM_OBJ-1:0] enable_q;
  logic [1:0] rx_sync_q;
  logic half_tick;
  logic sampled;

  // Address decode is shared by the read mux and the write paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  wire obj_ok = (page_q.object_number <= LAST_OBJ);
  wire [3:0] obj = page_q.object_number;
  wire [2:0] idx = page_q.data_byte_index;
  wire wr_page = SFR_WR && hit(SFR_ADDR, PAGE_OFS);
  wire wr_ctrl = SFR_WR && hit(SFR_ADDR, CTRL_OFS) && obj_ok;
  wire wr_stat = SFR_WR && hit(SFR_ADDR, STATUS_OFS) && obj_ok;
  wire wr_time = SFR_WR && hit(SFR_ADDR, TIMING_OFS);
  wire wr_data = SFR_WR && hit(SFR_ADDR, DATA_OFS) && obj_ok;
  wire data_acc = (SFR_WR || SFR_RD) && hit(SFR_ADDR, DATA_OFS);
  wire rx_ok = RX_FRAME_DONE && (RX_OBJECT <= LAST_OBJ);
  // Auto increment is active low; the 3-bit add wraps 7 to 0 by itself
  wire bump = data_acc && !page_q.index_autoinc_n;
  wire [2:0] idx_next = idx + 3'h1;

  // Read mux; an object number of 15 reads as zero
  wire [7:0] rd_mux =
    hit(SFR_ADDR, PAGE_OFS) ? page_q :
    hit(SFR_ADDR, TIMING_OFS) ? timing_q :
    !obj_ok ? 8'h00 :
    hit(SFR_ADDR, CTRL_OFS) ? ctrl_q[obj] :
    hit(SFR_ADDR, STATUS_OFS) ? {dlcw_q[obj], 7'h00} :
    hit(SFR_ADDR, DATA_OFS) ? data_q[obj][idx] : 8'h00;

  // Two-flop synchroniser on the bus pin
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rx_sync_q <= 2'h3;
    else
      rx_sync_q <= {rx_sync_q[0], CAN_RX};
  end

  // Page register: software write, else index advance on data access
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      page_q <= PAGE_RST;
    else if (wr_page)
      page_q <= SFR_WDATA;
    else if (bump)
      page_q.data_byte_index <= idx_next;
  end

  // Timing register; software only changes it with the controller off
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      timing_q <= TIMING_RST;
    else if (wr_time)
      timing_q <= SFR_WDATA; // Reserved bit kept as written
  end

  // Registered read data, held between reads
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rdata_q <= 8'h00;
    else if (SFR_RD)
      rdata_q <= rd_mux;
  end

  // Per-object control, status and enable state
  for (genvar g = 0; g < NUM_OBJ; g++)
  begin : g_obj
    wire sel = (obj == 4'(g));
    wire rx_hit = rx_ok && (RX_OBJECT == 4'(g));
    // Warning when the incoming length differs from the expected one
    wire mismatch = rx_hit && (RX_LENGTH != ctrl_q[g].data_length);

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
      if (SYS_RST)
        ctrl_q[g] <= CTRL_RST;
      else if (rx_hit)
        ctrl_q[g].data_length <= RX_LENGTH; // Frame wins over software
      else if (wr_ctrl && sel)
        ctrl_q[g] <= SFR_WDATA;
    end

    // Rewriting the configuration arms the object; disabled clears it
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
      if (SYS_RST)
        enable_q[g] <= 1'b0;
      else if (wr_ctrl && sel && !rx_hit)
        enable_q[g] <= (SFR_WDATA[7:6] != CFG_DISABLED); // A colliding frame drops the write and the enable holds
    end

    // Sticky warning; a new mismatch beats a clearing write
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
      if (SYS_RST)
        dlcw_q[g] <= 1'b0;
      else if (mismatch)
        dlcw_q[g] <= 1'b1;
      else if (wr_stat && sel)
        dlcw_q[g] <= SFR_WDATA[STATUS_DLCW_BIT];
    end

    // Data bytes are written through the data register at the index
    for (genvar b = 0; b < DATA_BYTES; b++)
    begin : g_byte
      always_ff @(posedge CLK)
      begin
        if (wr_data && sel && idx == 3'(b))
          data_q[g][b] <= SFR_WDATA;
      end
    end
  end

  cbt_bittime u_bittime (
    .clk(CLK),
    .rst(SYS_RST),
    .enable(CONTROLLER_ENABLE),
    .baud_prescaler(BAUD_PRESCALER),
    .prs(PROP_SEG),
    .resync_jump_width(RESYNC_JUMP_WIDTH),
    .cfg(timing_q),
    .rx(rx_sync_q[1]),
    .sampled(sampled),
    .half_tick(half_tick),
    .sample_bit_q(SAMPLE_BIT),
    .sample_strobe_q(SAMPLE_STROBE)
  );

  // Bus sampler, single or majority of three at the sample point
  cbt_sample3 u_sample (
    .clk(CLK),
    .rst(SYS_RST),
    .rx(rx_sync_q[1]),
    .half_tick(half_tick),
    .sample_type(timing_q.sample_type),
    .sampled(sampled)
  );

  // Per-object outputs come from flops; the loop only fans them out
  always_comb
  begin
    for (int i = 0; i < NUM_OBJ; i++)
    begin
      OBJECT_REPLY_VALID[i] = ctrl_q[i].reply_valid;
      OBJECT_ID_EXTENDED[i] = ctrl_q[i].id_extended;
    end
  end

  assign OBJECT_ENABLE = enable_q;
  assign SFR_RDATA = rdata_q;
endmodule // cbt_top
`default_nettype wire

/* tb.sv */
/* Self-checking bench for cbt_top with a far node on CAN_RX.
   Assumes cbt_pkg, cbt_top, cbt_can_node and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cbt_pkg::*;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ena = 1'b0;
  logic [5:0] baud_prescaler = 6'h00;
  logic [1:0] resync_jump_width = 2'h0;
  logic [14:0] obj_rv;
  logic [14:0] obj_ide;
  logic [2:0] prs = 3'h0;
  logic rx_done = 1'b0;
  logic [3:0] rx_obj = 4'h0;
  logic [3:0] rx_len = 4'h0;
  logic send = 1'b0;
  logic [7:0] bitc = 8'h04;
  logic [7:0] rdata;
  logic can_rx;
  logic s_bit;
  logic s_stb;
  logic [14:0] obj_en;
  logic [7:0] v;
  logic [7:0] tv;
  logic [3:0] o;
  logic [2:0] p1;
  logic [7:0] b [8];
  int seed = 29441;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  // 200 MHz clock
  always #2.5 CLK = ~CLK;
  cbt_top DUT (.CLK(CLK), .SYS_RST(SYS_RST), .SFR_ADDR(addr), .SFR_WR(wr_en), .SFR_RD(rd_en),
    .SFR_WDATA(wdata), .SFR_RDATA(rdata), .CONTROLLER_ENABLE(ena), .BAUD_PRESCALER(baud_prescaler),
    .PROP_SEG(prs), .RESYNC_JUMP_WIDTH(resync_jump_width), .CAN_RX(can_rx), .RX_FRAME_DONE(rx_done),
    .RX_OBJECT(rx_obj), .RX_LENGTH(rx_len), .SAMPLE_BIT(s_bit), .SAMPLE_STROBE(s_stb),
    .OBJECT_ENABLE(obj_en), .OBJECT_REPLY_VALID(obj_rv), .OBJECT_ID_EXTENDED(obj_ide));
  cbt_can_node u_node (.clk(CLK), .send(send), .bit_cycles(bitc), .pattern(16'h00FF),
    .can_rx(can_rx));
  // Nominal bit in clocks: sync, prop, phase one, phase two quanta
  function automatic logic [7:0] bit_len(input logic [7:0] t);
    return 8'((int'(baud_prescaler) + 1) * (4 + int'(prs) + int'(t[3:1]) + int'(t[6:4])));
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle strobes, then an idle cycle so no strobe is raised where it fell
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge CLK);
    wr_en = 1'b0;
    @(negedge CLK);
  endtask
  task automatic rd(input logic [7:0] a);
    addr = a;
    rd_en = 1'b1;
    @(negedge CLK);
    rd_en = 1'b0;
    v = rdata;
    @(negedge CLK);
  endtask
  // Clocks from one sample point to the next
  task automatic period(output int k);
    k = 0;
    while (s_stb !== 1'b1 && k < 2000)
    begin
      @(negedge CLK);
      k++;
    end
    k = 0;
    do
    begin
      @(negedge CLK);
      k++;
    end
    while (s_stb !== 1'b1 && k < 2000);
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A hang counts as a failure
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      stop_test();
    end
  end
  // Main sequence, driven on falling edges
  initial
  begin
    repeat (4) @(negedge CLK);
    SYS_RST = 1'b0;
    rd(PAGE_OFS);
    chk(v, 8'h00);
    repeat (3)
    begin
      o = 4'($unsigned($random(seed)) % 15);
      wr(PAGE_OFS, {o, 4'h0});
      for (int i = 0; i < 8; i++)
      begin
        b[i] = 8'($random(seed));
        wr(DATA_OFS, b[i]);
      end
      rd(PAGE_OFS);
      chk(v, {o, 4'h0});
      for (int i = 0; i < 8; i++)
      begin
        rd(DATA_OFS);
        chk(v, b[i]);
      end
      wr(PAGE_OFS, {o, 4'hD});
      rd(DATA_OFS);
      rd(DATA_OFS);
      chk(v, b[5]);
      for (int c = 0; c < 4; c++)
      begin
        tv = {2'(c), 2'($random(seed)), 4'h8};
        wr(CTRL_OFS, tv);
        rd(CTRL_OFS);
        chk(v, tv);
        chk({7'h00, obj_en[o]}, {7'h00, c != 0});
        chk({7'h00, obj_rv[o]}, {7'h00, tv[5]});
        chk({7'h00, obj_ide[o]}, {7'h00, tv[4]});
      end
      // Frame report with a random legal length, then clear the warning
      rx_len = 4'($unsigned($random(seed)) % 9);
      rx_obj = o;
      rx_done = 1'b1;
      @(negedge CLK);
      rx_done = 1'b0;
      rd(CTRL_OFS);
      chk({4'h0, v[3:0]}, {4'h0, rx_len});
      rd(STATUS_OFS);
      chk(v, {rx_len != MAX_DLC, 7'h00});
      wr(STATUS_OFS, 8'h00);
    end
    wr(PAGE_OFS, 8'hF0);
    rd(CTRL_OFS);
    chk(v, 8'h00);
    // Mid-run reset brings the page back to object 0, index 0
    SYS_RST = 1'b1;
    @(negedge CLK);
    SYS_RST = 1'b0;
    rd(PAGE_OFS);
    chk(v, PAGE_RST);
    // Timing written only while disabled, reserved bit kept clear
    for (int t = 0; t < 4; t++)
    begin
      p1 = 3'($unsigned($random(seed)) % 4);
      tv = {1'b0, p1 + 3'(1 + $unsigned($random(seed)) % 3), p1, 1'b0};
      baud_prescaler = 6'($unsigned($random(seed)) % 3);
      prs = 3'($random(seed));
      wr(TIMING_OFS, tv);
      rd(TIMING_OFS);
      chk(v, tv);
      ena = 1'b1;
      period(n);
      chk(8'(n), bit_len(tv));
      ena = 1'b0;
    end
    // Dominant bits from the far node, for each sample type
    for (int s = 0; s < 2; s++)
    begin
      wr(TIMING_OFS, tv | 8'(s));
      bitc = bit_len(tv);
      resync_jump_width = 2'($random(seed));
      ena = 1'b1;
      send = 1'b1;
      @(negedge CLK);
      send = 1'b0;
      repeat (4) period(n);
      chk({7'h00, s_bit}, 8'h00);
      repeat (20) period(n);
      chk({7'h00, s_bit}, 8'h01);
      ena = 1'b0;
    end
    stop_test();
  end
endmodule // tb
`default_nettype wire
